// File: pkg/irlink_bus_if.sv
// host register port, interrupt and dma handshake between host and controller
`timescale 1ns/1ps
interface irlink_bus_if;
  logic chip_select_n;
  logic read_n;
  logic write_n;
  logic [3:0] register_index;
  logic [7:0] host_d_out;
  logic host_d_oe;
  logic [7:0] dev_d_out;
  logic dev_d_oe;
  logic [7:0] host_data_bus;
  logic interrupt_n;
  logic dma_request;
  logic dma_acknowledge;
  logic dma_terminal_end_n;

  // resolved bus level; an undriven bus floats high
  assign host_data_bus = dev_d_oe ? dev_d_out : (host_d_oe ? host_d_out : 8'hff);

  modport dev (
    input chip_select_n, read_n, write_n, register_index, host_data_bus,
    input dma_acknowledge, dma_terminal_end_n,
    output dev_d_out, dev_d_oe, interrupt_n, dma_request
  );
  modport host (
    output chip_select_n, read_n, write_n, register_index, host_d_out, host_d_oe,
    output dma_acknowledge, dma_terminal_end_n,
    input host_data_bus, interrupt_n, dma_request
  );
endinterface

// File: pkg/irlink_pkg.sv
// constants shared by the infrared link controller and its host end
package irlink_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int CLK_PERIOD_NS = 10;
  // crystal figures, not used; the timing scales from CLK_HZ and the core runs on core_clk_i
  localparam int XTAL_SLOW_HZ = 18432000;
  localparam int XTAL_FAST_HZ = 48000000;
  // register indexes
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_POL = 4'h2;
  localparam logic [3:0] REG_RATE = 4'h3;
  localparam logic [3:0] REG_IEN = 4'h4;
  localparam logic [3:0] REG_ISTAT = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  // control bits
  localparam int CTRL_TX_GO = 0;
  localparam int CTRL_DMA_EN = 1;
  localparam int CTRL_DMA_TX = 2;
  localparam int CTRL_RX_EN = 3;
  // polarity bits, a one selects active low
  localparam int POL_RXA = 0;
  localparam int POL_RXB = 1;
  localparam int POL_SHDN = 2;
  localparam int POL_DMA_REQUEST = 3;
  localparam int POL_DMA_ACKNOWLEDGE = 4;
  // interrupt event bits
  localparam int EV_TX_DONE = 0;
  localparam int EV_RX_GOOD = 1;
  localparam int EV_RX_CRC = 2;
  localparam int EV_DMA_END = 3;
  localparam int EV_RX_OVF = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // rate codes 0..8: 2400 .. 115200, then 0.576, 1.152, 4 Mbit/s
  localparam logic [3:0] RATE_LAST = 4'h8;
  localparam logic [3:0] RATE_FAST_MIN = 4'h6;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  localparam logic [7:0] BOF_BYTE = 8'hc0;
  localparam logic [7:0] EOF_BYTE = 8'hc1;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8;
  // host strobe timing
  localparam int T_PULSE_NS = 120;
  localparam int T_SETUP_NS = 60;
  localparam int T_RECOV_NS = 60;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_CYC = (T_RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: rtl/irlink_ctrl.sv
// infrared link controller: host register port, fifos, framing, crc, pins
`timescale 1ns/1ps
// Operation
// R1 - register access only while chip select low
// R2 - read strobe low drives addressed register
// R3 - write strobe low captures bus data
// R4 - interrupt output low while request pending
// R5 - terminal count low ends dma transfer
// R6 - power down input freezes the engines
// R7 - shutdown output asserted during power down
// R8 - reset input restores initial register values
// R9 - transmit output high means light pulse
// R10 - receive, shutdown, dma pins polarity selectable
// R11 - 32 byte transmit and receive fifos
// R12 - crc generated on transmit, checked receive
// R13 - receive strips frame start and end markers
// R14 - transmit inserts frame start and end markers
// R15 - nine rates from 2400 to 4M
// R16 - timing derived from crystal based rate; the code divides CLK_HZ instead
// R17 - second receive input only at fast rates
// R18 - unused second receive input tied fixed
// R19 - dma request and acknowledged data transfer
// R20 - four index bits decode sixteen locations
module irlink_ctrl (
  // clock and resets
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic sys_reset_n_i,
  input wire logic power_down_n_i,
  // host side
  irlink_bus_if.dev bus,
  // transceiver side
  input wire logic infrared_rx_primary_i,
  input wire logic infrared_rx_fast_i,
  output logic infrared_tx_out_o,
  output logic transceiver_shutdown_o
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DATA = 2'b01,
    TX_CRCH = 2'b10,
    TX_EOF = 2'b11
  } tx_state_e;

  function automatic logic [15:0] rate_div(input logic [3:0] sel);
    int bps;
    case (sel)
      4'h0: bps = 2400;
      4'h1: bps = 9600;
      4'h2: bps = 19200;
      4'h3: bps = 38400;
      4'h4: bps = 57600;
      4'h5: bps = 115200;
      4'h6: bps = 576000;
      4'h7: bps = 1152000;
      default: bps = 4000000;
    endcase
    rate_div = 16'(irlink_pkg::CLK_HZ / bps);
  endfunction

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ irlink_pkg::CRC_POLY) : (r >> 1);
    end
    crc_upd = r;
  endfunction

  logic rst;
  logic [7:0] ctrl_reg, pol_reg, ien_reg, ist_reg;
  logic [3:0] rate_reg;
  logic [15:0] div;
  logic [7:0] tx_mem [irlink_pkg::FIFO_DEPTH];
  logic [7:0] rx_mem [irlink_pkg::FIFO_DEPTH];
  logic [5:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic tx_empty, tx_full, rx_empty, rx_full;
  logic cpu_rd, cpu_wr, dma_acknowledge_act, rd_any, wr_any, rd_q_reg, wr_q_reg;
  logic rd_start, wr_start, dma_rd_start, dma_wr_start;
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic [7:0] ev, clr;
  logic [7:0] dout_reg;
  logic doe_reg, intr_n_reg, dma_request_reg, shdn_reg, ir_out_reg;
  tx_state_e tx_state_reg;
  logic [15:0] tx_crc_reg, tx_cnt_reg;
  logic [9:0] tx_sh_reg;
  logic [3:0] tx_bits_reg;
  logic tx_busy_reg, tx_load, tx_done;
  logic [7:0] tx_byte;
  logic rx_in, rx_busy_reg, rx_seen_reg, rx_done_reg, rx_frame_reg;
  logic [15:0] rx_cnt_reg, rx_crc_reg;
  logic [3:0] rx_bits_reg;
  logic [7:0] rx_sh_reg, rx_byte_reg;
  logic rx_data_byte;

  assign rst = srst_i | ~sys_reset_n_i; // [R8]
  assign div = rate_div(rate_reg); // [R15] [R16]
  assign tx_empty = tx_wp_reg == tx_rp_reg;
  assign tx_full = tx_wp_reg == {~tx_rp_reg[5], tx_rp_reg[4:0]};
  assign rx_empty = rx_wp_reg == rx_rp_reg;
  assign rx_full = rx_wp_reg == {~rx_rp_reg[5], rx_rp_reg[4:0]};

  // host strobes; a dma acknowledge replaces chip select and index
  assign cpu_rd = ~bus.chip_select_n & ~bus.read_n; // [R1] [R2]
  assign cpu_wr = ~bus.chip_select_n & ~bus.write_n; // [R1] [R3]
  assign dma_acknowledge_act = bus.dma_acknowledge ^ pol_reg[irlink_pkg::POL_DMA_ACKNOWLEDGE]; // [R10]
  assign rd_any = cpu_rd | (dma_acknowledge_act & ~bus.read_n);
  assign wr_any = cpu_wr | (dma_acknowledge_act & ~bus.write_n);
  assign rd_start = rd_any & ~rd_q_reg;
  assign wr_start = wr_any & ~wr_q_reg;
  assign dma_rd_start = rd_start & dma_acknowledge_act; // [R19]
  assign dma_wr_start = wr_start & dma_acknowledge_act; // [R19]
  assign tx_push = ((wr_start & ~dma_acknowledge_act & bus.register_index == irlink_pkg::REG_DATA)
                    | dma_wr_start) & ~tx_full; // [R11]
  assign rx_pop = ((rd_start & ~dma_acknowledge_act & bus.register_index == irlink_pkg::REG_DATA)
                   | dma_rd_start) & ~rx_empty;
  assign clr = (wr_start & ~dma_acknowledge_act & bus.register_index == irlink_pkg::REG_ISTAT)
               ? bus.host_data_bus : 8'h00;

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      rd_q_reg <= 1'b0;
      wr_q_reg <= 1'b0;
    end else begin
      rd_q_reg <= rd_any;
      wr_q_reg <= wr_any;
    end
  end

  // register writes; terminal count and transmit start clear control bits
  always_ff @(posedge core_clk_i) begin
    if (rst) begin // [R8]
      ctrl_reg <= irlink_pkg::RESET_BYTE;
      pol_reg <= irlink_pkg::RESET_BYTE;
      rate_reg <= 4'h0;
      ien_reg <= irlink_pkg::RESET_BYTE;
    end else begin
      if (wr_start & ~dma_acknowledge_act) begin // [R3] [R20]
        case (bus.register_index)
          irlink_pkg::REG_CTRL: ctrl_reg <= bus.host_data_bus;
          irlink_pkg::REG_POL: pol_reg <= bus.host_data_bus;
          irlink_pkg::REG_RATE: begin
            if (bus.host_data_bus[3:0] <= irlink_pkg::RATE_LAST) begin
              rate_reg <= bus.host_data_bus[3:0];
            end
          end
          irlink_pkg::REG_IEN: ien_reg <= bus.host_data_bus;
          default: ;
        endcase
      end
      if (tx_state_reg == TX_IDLE && ctrl_reg[irlink_pkg::CTRL_TX_GO] && power_down_n_i) begin
        ctrl_reg[irlink_pkg::CTRL_TX_GO] <= 1'b0;
      end
      if (dma_acknowledge_act && !bus.dma_terminal_end_n) begin
        ctrl_reg[irlink_pkg::CTRL_DMA_EN] <= 1'b0; // [R5]
      end
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  always_comb begin
    ev = 8'h00;
    ev[irlink_pkg::EV_TX_DONE] = tx_done;
    ev[irlink_pkg::EV_RX_GOOD] = rx_done_reg & rx_frame_reg
                                 & rx_byte_reg == irlink_pkg::EOF_BYTE
                                 & crc_upd(rx_crc_reg, 8'h00) == crc_upd(irlink_pkg::CRC_GOOD, 8'h00);
    ev[irlink_pkg::EV_RX_CRC] = rx_done_reg & rx_frame_reg
                                & rx_byte_reg == irlink_pkg::EOF_BYTE
                                & rx_crc_reg != irlink_pkg::CRC_GOOD; // [R12]
    ev[irlink_pkg::EV_DMA_END] = dma_acknowledge_act & ~bus.dma_terminal_end_n; // [R5]
    ev[irlink_pkg::EV_RX_OVF] = rx_data_byte & rx_full;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      ist_reg <= irlink_pkg::RESET_BYTE;
      intr_n_reg <= 1'b1;
      dma_request_reg <= 1'b0;
      shdn_reg <= 1'b0;
    end else begin
      ist_reg <= (ist_reg & ~clr) | ev;
      intr_n_reg <= ~|(ist_reg & ien_reg); // [R4]
      dma_request_reg <= (ctrl_reg[irlink_pkg::CTRL_DMA_EN]
                   & (ctrl_reg[irlink_pkg::CTRL_DMA_TX] ? ~tx_full : ~rx_empty))
                  ^ pol_reg[irlink_pkg::POL_DMA_REQUEST]; // [R19] [R10]
      shdn_reg <= ~power_down_n_i ^ pol_reg[irlink_pkg::POL_SHDN]; // [R7] [R10]
    end
  end

  // read data is latched when the strobe opens and held until it closes
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      dout_reg <= 8'h00;
      doe_reg <= 1'b0;
    end else begin
      doe_reg <= rd_any; // [R2]
      if (dma_rd_start) begin
        dout_reg <= rx_mem[rx_rp_reg[4:0]]; // [R19]
      end else if (rd_start) begin
        case (bus.register_index) // [R20]
          irlink_pkg::REG_DATA: dout_reg <= rx_mem[rx_rp_reg[4:0]];
          irlink_pkg::REG_CTRL: dout_reg <= ctrl_reg;
          irlink_pkg::REG_POL: dout_reg <= pol_reg;
          irlink_pkg::REG_RATE: dout_reg <= {4'h0, rate_reg};
          irlink_pkg::REG_IEN: dout_reg <= ien_reg;
          irlink_pkg::REG_ISTAT: dout_reg <= ist_reg;
          irlink_pkg::REG_STATUS: dout_reg <= {1'b0, rx_frame_reg, rx_busy_reg,
                                               tx_state_reg != TX_IDLE,
                                               rx_full, rx_empty, tx_full, tx_empty};
          default: dout_reg <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      tx_wp_reg <= 6'h00;
      tx_rp_reg <= 6'h00;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_reg[4:0]] <= bus.host_data_bus; // [R11]
        tx_wp_reg <= tx_wp_reg + 6'h01;
      end
      if (tx_pop) begin
        tx_rp_reg <= tx_rp_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      rx_wp_reg <= 6'h00;
      rx_rp_reg <= 6'h00;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_reg[4:0]] <= rx_byte_reg; // [R11]
        rx_wp_reg <= rx_wp_reg + 6'h01;
      end
      if (rx_pop) begin
        rx_rp_reg <= rx_rp_reg + 6'h01;
      end
    end
  end

  // transmit framer: start marker, fifo bytes, inverted crc, end marker
  always_comb begin
    tx_load = ~tx_busy_reg & tx_state_reg != TX_IDLE & power_down_n_i;
    tx_pop = tx_load & tx_state_reg == TX_DATA & ~tx_empty;
    tx_done = tx_load & tx_state_reg == TX_EOF;
    case (tx_state_reg)
      TX_DATA: tx_byte = tx_empty ? ~tx_crc_reg[7:0] : tx_mem[tx_rp_reg[4:0]];
      TX_CRCH: tx_byte = ~tx_crc_reg[15:8]; // [R12]
      TX_EOF: tx_byte = irlink_pkg::EOF_BYTE; // [R14]
      default: tx_byte = irlink_pkg::BOF_BYTE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      tx_state_reg <= TX_IDLE;
      tx_crc_reg <= irlink_pkg::CRC_INIT;
      tx_busy_reg <= 1'b0;
      tx_sh_reg <= 10'h3ff;
      tx_bits_reg <= 4'h0;
      tx_cnt_reg <= 16'h0000;
      ir_out_reg <= 1'b0;
    end else if (power_down_n_i) begin // [R6]
      if (tx_state_reg == TX_IDLE && ctrl_reg[irlink_pkg::CTRL_TX_GO]) begin
        tx_busy_reg <= 1'b1; // [R14]
        tx_sh_reg <= {1'b1, irlink_pkg::BOF_BYTE, 1'b0};
        tx_bits_reg <= 4'ha;
        tx_cnt_reg <= 16'h0000;
        tx_crc_reg <= irlink_pkg::CRC_INIT;
        tx_state_reg <= TX_DATA;
      end else if (tx_load) begin
        tx_busy_reg <= 1'b1;
        tx_sh_reg <= {1'b1, tx_byte, 1'b0};
        tx_bits_reg <= 4'ha;
        tx_cnt_reg <= 16'h0000;
        case (tx_state_reg)
          TX_DATA: begin
            if (tx_empty) begin
              tx_state_reg <= TX_CRCH;
            end else begin
              tx_crc_reg <= crc_upd(tx_crc_reg, tx_byte); // [R12]
            end
          end
          TX_CRCH: tx_state_reg <= TX_EOF;
          default: tx_state_reg <= TX_IDLE;
        endcase
      end else if (tx_busy_reg) begin
        if (tx_cnt_reg == div - 16'h0001) begin
          tx_cnt_reg <= 16'h0000;
          tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
          tx_bits_reg <= tx_bits_reg - 4'h1;
          tx_busy_reg <= tx_bits_reg != 4'h1;
        end else begin
          tx_cnt_reg <= tx_cnt_reg + 16'h0001;
        end
      end
      // a zero bit is a light pulse of three sixteenths of the bit time
      ir_out_reg <= tx_busy_reg & ~tx_sh_reg[0]
                    & (tx_cnt_reg < {div[15:4], 1'b0} + {4'h0, div[15:4]}); // [R9]
    end
  end

  // receiver: a pulse anywhere in a bit window marks a zero bit
  // receive A is heard at every rate, receive B joins it only at the fast rates
  assign rx_in = (infrared_rx_primary_i ^ pol_reg[irlink_pkg::POL_RXA])
                 | ((rate_reg >= irlink_pkg::RATE_FAST_MIN)
                    & (infrared_rx_fast_i ^ pol_reg[irlink_pkg::POL_RXB])); // [R17] [R10] [R18]
  assign rx_data_byte = rx_done_reg & rx_frame_reg & rx_byte_reg != irlink_pkg::EOF_BYTE
                        & rx_byte_reg != irlink_pkg::BOF_BYTE;
  assign rx_push = rx_data_byte & ~rx_full; // [R13]

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      rx_busy_reg <= 1'b0;
      rx_seen_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_bits_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_done_reg <= 1'b0;
      rx_byte_reg <= 8'h00;
    end else if (power_down_n_i) begin // [R6]
      rx_done_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (rx_in && ctrl_reg[irlink_pkg::CTRL_RX_EN]) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= 16'h0000;
          rx_bits_reg <= 4'h0;
          rx_seen_reg <= 1'b0;
        end
      end else if (rx_cnt_reg == div - 16'h0001) begin
        rx_cnt_reg <= 16'h0000;
        rx_seen_reg <= 1'b0;
        rx_bits_reg <= rx_bits_reg + 4'h1;
        if (rx_bits_reg != 4'h0 && rx_bits_reg != 4'h9) begin
          // the edge that closes a window already sees the next bit's pulse
          rx_sh_reg <= {~rx_seen_reg, rx_sh_reg[7:1]};
        end
        if (rx_bits_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          rx_done_reg <= 1'b1;
          rx_byte_reg <= rx_sh_reg;
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg + 16'h0001;
        rx_seen_reg <= rx_seen_reg | rx_in;
      end
    end
  end

  // frame markers open and close a frame and never reach the fifo
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      rx_frame_reg <= 1'b0;
      rx_crc_reg <= irlink_pkg::CRC_INIT;
    end else if (rx_done_reg) begin
      if (rx_byte_reg == irlink_pkg::BOF_BYTE) begin // [R13]
        rx_frame_reg <= 1'b1;
        rx_crc_reg <= irlink_pkg::CRC_INIT;
      end else if (rx_byte_reg == irlink_pkg::EOF_BYTE) begin // [R13]
        rx_frame_reg <= 1'b0;
      end else if (rx_frame_reg) begin
        rx_crc_reg <= crc_upd(rx_crc_reg, rx_byte_reg); // [R12]
      end
    end
  end

  assign bus.dev_d_out = dout_reg;
  assign bus.dev_d_oe = doe_reg;
  assign bus.interrupt_n = intr_n_reg;
  assign bus.dma_request = dma_request_reg;
  assign infrared_tx_out_o = ir_out_reg;
  assign transceiver_shutdown_o = shdn_reg;
endmodule

// File: rtl/irlink_host.sv
// host end: runs register and dma bus cycles for a user-side command port
`timescale 1ns/1ps
module irlink_host (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_dma_i,
  input wire logic cmd_last_i,
  input wire logic [3:0] cmd_index_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic dma_acknowledge_active_low_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  // device line
  irlink_bus_if.host bus
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SETUP = 2'b01,
    H_STROBE = 2'b10,
    H_RECOV = 2'b11
  } host_state_e;

  host_state_e state_reg;
  logic [7:0] cnt_reg, wdata_reg, rdata_reg;
  logic write_reg, dma_reg, last_reg, rvalid_reg;
  logic cs_n_reg, rd_n_reg, wr_n_reg, oe_reg, dma_acknowledge_reg, tc_n_reg;
  logic [3:0] index_reg;

  // chip select and acknowledge open before the strobe and close after it
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= H_IDLE;
      cnt_reg <= 8'h00;
      {write_reg, dma_reg, last_reg, rvalid_reg} <= 4'h0;
      {cs_n_reg, rd_n_reg, wr_n_reg} <= 3'b111;
      {oe_reg, dma_acknowledge_reg, tc_n_reg} <= 3'b001;
      index_reg <= 4'h0;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      rvalid_reg <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (cmd_valid_i) begin
            write_reg <= cmd_write_i;
            dma_reg <= cmd_dma_i;
            last_reg <= cmd_last_i;
            index_reg <= cmd_index_i;
            wdata_reg <= cmd_wdata_i;
            oe_reg <= cmd_write_i;
            cs_n_reg <= cmd_dma_i; // [R1]
            dma_acknowledge_reg <= cmd_dma_i; // [R19]
            cnt_reg <= 8'(irlink_pkg::SETUP_CYC - 1);
            state_reg <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (cnt_reg == 8'h00) begin
            rd_n_reg <= write_reg; // [R2]
            wr_n_reg <= ~write_reg; // [R3]
            tc_n_reg <= ~(dma_reg & last_reg); // [R5]
            cnt_reg <= 8'(irlink_pkg::PULSE_CYC - 1);
            state_reg <= H_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        H_STROBE: begin
          if (cnt_reg == 8'h00) begin
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            tc_n_reg <= 1'b1;
            rdata_reg <= bus.host_data_bus; // [R2]
            rvalid_reg <= ~write_reg;
            cnt_reg <= 8'(irlink_pkg::RECOV_CYC - 1);
            state_reg <= H_RECOV;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        H_RECOV: begin
          cs_n_reg <= 1'b1;
          dma_acknowledge_reg <= 1'b0;
          oe_reg <= 1'b0;
          if (cnt_reg == 8'h00) begin
            state_reg <= H_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  assign cmd_ready_o = state_reg == H_IDLE;
  assign rsp_valid_o = rvalid_reg;
  assign rsp_data_o = rdata_reg;
  assign bus.chip_select_n = cs_n_reg;
  assign bus.read_n = rd_n_reg;
  assign bus.write_n = wr_n_reg;
  assign bus.register_index = index_reg;
  assign bus.host_d_out = wdata_reg;
  assign bus.host_d_oe = oe_reg;
  assign bus.dma_acknowledge = dma_acknowledge_reg ^ dma_acknowledge_active_low_i;
  assign bus.dma_terminal_end_n = tc_n_reg;
endmodule

// File: verif/irlink_chk.sv
// assertions on the host bus and transceiver pins of the infrared link controller
`timescale 1ns/1ps
module irlink_chk (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // host bus
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic dev_d_oe,
  input wire logic interrupt_n,
  input wire logic dma_request,
  input wire logic dma_acknowledge,
  // transceiver pins
  input wire logic power_down_n_i,
  input wire logic infrared_tx_out_o,
  input wire logic transceiver_shutdown_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_read_go;
    !chip_select_n && $fell(read_n);
  endsequence
  sequence s_read_end;
    !read_n ##1 read_n;
  endsequence
  a_oe_cause: assert property ($rose(dev_d_oe) |-> $past(!read_n))
    else $error("data bus driven without a read strobe");
  a_read_drive: assert property (s_read_go |=> dev_d_oe)
    else $error("read strobe not answered");
  a_oe_release: assert property (s_read_end |=> !dev_d_oe)
    else $error("data bus held after read strobe");
  // acknowledge is active high here: the bench never sets its polarity bit
  a_cs_gate: assert property ((chip_select_n && !dma_acknowledge) [*2] |-> !dev_d_oe)
    else $error("data bus driven while not selected");
  a_write_quiet: assert property (!write_n |-> !dev_d_oe)
    else $error("data bus driven during a write");
  a_shutdown_follow: assert property ($changed(power_down_n_i) |=>
    $changed(transceiver_shutdown_o))
    else $error("shutdown did not follow power down");
  a_tx_frozen: assert property ($rose(infrared_tx_out_o) |-> $past(power_down_n_i))
    else $error("light pulse started in power down");
  a_reset_state: assert property (disable iff (1'b0) srst_i |=>
    interrupt_n && !dma_request && !dev_d_oe)
    else $error("outputs not initial after reset");
endmodule

// File: verif/testbench.sv
// self-checking bench: host end and controller joined through the bus interface
`timescale 1ns/1ps
module testbench;
  logic clk, srst, pd_n, c_valid, c_write, c_dma, c_last, c_ready, rsp_valid, tx_out, shutdown;
  logic [3:0] c_index;
  logic [7:0] c_wdata, rsp_data;
  logic [7:0] exp_q[$];
  logic [7:0] frame[3];
  logic [15:0] crc;
  logic sys_rst_n;
  int errors, n_compared, seed, n;
  irlink_bus_if bus();
  // transmit looped into receive A; a single-output module leaves receive B tied low
  irlink_ctrl i_irlink_ctrl(.core_clk_i(clk), .srst_i(srst), .sys_reset_n_i(sys_rst_n),
    .power_down_n_i(pd_n), .bus(bus), .infrared_rx_primary_i(tx_out),
    .infrared_rx_fast_i(1'b0),
    .infrared_tx_out_o(tx_out), .transceiver_shutdown_o(shutdown));
  irlink_host i_irlink_host(.core_clk_i(clk), .srst_i(srst), .cmd_valid_i(c_valid),
    .cmd_write_i(c_write), .cmd_dma_i(c_dma), .cmd_last_i(c_last), .cmd_index_i(c_index),
    .cmd_wdata_i(c_wdata), .dma_acknowledge_active_low_i(1'b0), .cmd_ready_o(c_ready),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .bus(bus));
  irlink_chk i_chk(.core_clk_i(clk), .srst_i(srst), .chip_select_n(bus.chip_select_n),
    .read_n(bus.read_n), .write_n(bus.write_n), .dev_d_oe(bus.dev_d_oe),
    .interrupt_n(bus.interrupt_n), .dma_request(bus.dma_request),
    .dma_acknowledge(bus.dma_acknowledge), .power_down_n_i(pd_n),
    .infrared_tx_out_o(tx_out), .transceiver_shutdown_o(shutdown));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic marker(input logic [7:0] b);
    return b == irlink_pkg::BOF_BYTE || b == irlink_pkg::EOF_BYTE;
  endfunction
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic sync();
    n = 0;
    while (c_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (c_ready !== 1'b1) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic cmd(input logic w, d, l, input logic [3:0] i, input logic [7:0] wd, exp);
    sync();
    @(posedge clk);
    {c_valid, c_write, c_dma, c_last, c_index, c_wdata} <= {1'b1, w, d, l, i, wd};
    if (!w) exp_q.push_back(exp);
    @(posedge clk);
    c_valid <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] wd);
    cmd(1'b1, 1'b0, 1'b0, i, wd, 8'h00);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] exp);
    cmd(1'b0, 1'b0, 1'b0, i, 8'h00, exp);
  endtask
  task automatic pin(input logic pd, input logic [7:0] exp);
    @(posedge clk);
    pd_n <= pd;
    repeat (3) @(posedge clk);
    #1;
    check({7'h00, shutdown}, exp);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // the response stands one cycle, so it is taken at the edge that shows it
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) check(rsp_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  end
  initial begin
    seed = 34353;
    errors = 0;
    n_compared = 0;
    {srst, pd_n, sys_rst_n} = 3'b111;
    {c_valid, c_write, c_dma, c_last, c_index, c_wdata} = '0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    #1;
    for (int i = 1; i < 16; i++) rd(4'(i), (i == 6) ? 8'h05 : 8'h00);
    $display("reset values done");
    for (int i = 0; i < 10; i++) begin
      wr(irlink_pkg::REG_RATE, 8'(i));
      rd(irlink_pkg::REG_RATE, (i > 8) ? 8'h08 : 8'(i));
    end
    $display("rates done");
    pin(1'b0, 8'h01);
    wr(irlink_pkg::REG_POL, 8'h04);
    sync();
    check({7'h00, shutdown}, 8'h00);
    pin(1'b1, 8'h01);
    wr(irlink_pkg::REG_POL, 8'h00);
    $display("power down done");
    n = 0;
    do begin
      foreach (frame[i]) frame[i] = 8'($random(seed));
      crc = 16'hffff;
      foreach (frame[i]) begin
        crc = crc ^ {8'h00, frame[i]};
        repeat (8) crc = crc[0] ? (crc >> 1) ^ 16'h8408 : crc >> 1;
      end
      n++;
      // no escaping on the link: a marker value inside the frame would cut it
    end while (n < 50 && (marker(frame[0]) || marker(frame[1]) || marker(frame[2])
                          || marker(~crc[7:0]) || marker(~crc[15:8])));
    wr(irlink_pkg::REG_CTRL, 8'h06);
    sync();
    check({7'h00, bus.dma_request}, 8'h01);
    cmd(1'b1, 1'b1, 1'b1, 4'h0, frame[0], 8'h00);
    rd(irlink_pkg::REG_CTRL, 8'h04);
    rd(irlink_pkg::REG_ISTAT, 8'h08);
    wr(irlink_pkg::REG_ISTAT, 8'h08);
    sync();
    check({7'h00, bus.dma_request}, 8'h00);
    $display("dma done");
    wr(irlink_pkg::REG_DATA, frame[1]);
    wr(irlink_pkg::REG_DATA, frame[2]);
    wr(irlink_pkg::REG_RATE, 8'h08);
    wr(irlink_pkg::REG_IEN, 8'h02);
    wr(irlink_pkg::REG_CTRL, 8'h09);
    n = 0;
    while (bus.interrupt_n !== 1'b0 && n < 30000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({7'h00, bus.interrupt_n}, 8'h00);
    if (bus.interrupt_n !== 1'b0) end_of_test();
    foreach (frame[i]) rd(irlink_pkg::REG_DATA, frame[i]);
    rd(irlink_pkg::REG_DATA, ~crc[7:0]);
    rd(irlink_pkg::REG_DATA, ~crc[15:8]);
    rd(irlink_pkg::REG_ISTAT, 8'h03);
    wr(irlink_pkg::REG_ISTAT, 8'h03);
    sync();
    check({7'h00, bus.interrupt_n}, 8'h01);
    rd(irlink_pkg::REG_STATUS, 8'h05);
    $display("frame loopback done");
    wr(irlink_pkg::REG_CTRL, 8'h00);
    for (int i = 0; i < 33; i++) begin
      if (i == 31) rd(irlink_pkg::REG_STATUS, 8'h04);
      wr(irlink_pkg::REG_DATA, 8'($random(seed)));
    end
    rd(irlink_pkg::REG_STATUS, 8'h06);
    wr(irlink_pkg::REG_POL, 8'h08);
    sync();
    check({7'h00, bus.dma_request}, 8'h01);
    @(posedge clk);
    sys_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    sys_rst_n <= 1'b1;
    rd(irlink_pkg::REG_STATUS, 8'h05);
    rd(irlink_pkg::REG_POL, 8'h00);
    sync();
    check(8'(exp_q.size()), 8'h00);
    $display("fifo fill done");
    end_of_test();
  end
endmodule
